// ==== btc_regs.svh ====
// Register offsets, field positions, reset values and encodings
`ifndef BTC_REGS_SVH
`define BTC_REGS_SVH
`define BTC_CTRL_OFS 32'h0000_0000
`define BTC_PARITY_ERROR_REGISTER_OFS 32'h0000_0004
`define BTC_STAT_OFS 32'h0000_0008
`define BTC_CTRL_RST 4'h0
`define BTC_PARITY_ERROR_REGISTER_RST 8'h00
`define BTC_CTRL_MODE64 0
`define BTC_CTRL_KERNEL 1
`define BTC_CTRL_SCC_EN 2
`define BTC_CTRL_PAR_OVR 3
`define BTC_OP_REGISTER_IMMEDIATE_CLASS 6'h01
`define BTC_OP_SPECIAL 6'h00
`define BTC_OP_BNE 6'h05
`define BTC_OP_BRANCH_UNEQUAL_LIKELY 6'h15
`define BTC_OP_LINE 6'h2F
`define BTC_FN_TRAP 6'h0D
`define BTC_RT_BNL 5'h10
`define BTC_RT_BNLL 5'h12
`define BTC_RT_BNLK 5'h02
`define BTC_LINK_REG 5'h1F
`define BTC_CACHE_I 2'h0
`define BTC_CACHE_D 2'h1
`define BTC_MOP_HITINV 3'h4
`define BTC_MOP_HITWBI 3'h5
`define BTC_MOP_HITWB 3'h6
`define BTC_STORE_LOG2 12
`define BTC_BLOCK_LOG2 4
`define BTC_RESP_OKAY 2'h0
`define BTC_RESP_SLVERR 2'h2
`endif

// ==== btc_pkg.sv ====
// Types shared by the branch, trap and line maintenance decoder
package btc_pkg;
  typedef enum logic [1:0] {
    BTC_IDLE = 2'b01,
    BTC_SLOT = 2'b10
  } btc_state_e;

  typedef struct packed {
    logic go;
    logic [1:0] cache_sel;
    logic [2:0] mop;
    logic [63:0] vaddr;
    logic [7:0] index;
    logic dword;
    logic hit_op;
    logic use_parity_error_register;
    logic [7:0] parity_error_register;
  } btc_creq_s;

  typedef struct packed {
    logic redirect;
    logic [63:0] target;
    logic nullify;
    logic link_we;
    logic [4:0] link_idx;
    logic [63:0] link_data;
    logic brk_exc;
    logic cpu_exc;
  } btc_pipe_s;

  typedef struct packed {
    btc_state_e fsm;
    logic pend_taken;
    logic pend_likely;
    logic [63:0] pend_target;
    btc_pipe_s po;
    btc_creq_s creq;
    logic [3:0] ctrl;
    logic [7:0] parity_error_register;
    logic [2:0] evt;
    logic aw_have;
    logic [31:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } btc_state_s;
endpackage

// ==== btc_decode.sv ====
// Branch, breakpoint trap and line maintenance decode with AXI4-Lite regs
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "btc_regs.svh"

// How it works
// - Target is sign-extended offset shifted by two plus the slot address.
// - Taken branch redirects the counter after the slot issues, at T+1.
// - Class 000001 with second field 10000 is branch_negative_link.
// - Class 000001 with second field 10010 is the linking likely form.
// - Class 000001 with second field 00010 is branch_negative_likely.
// - Opcodes 000101 and 010101 are the unequal branches on two sources.
// - Linking forms always write PC plus 8 into register 31.
// - Negative branches take on the sign bit, 31 or 63 by mode.
// - A linking branch whose source is register 31 raises no trap.
// - A likely branch not taken nullifies its delay slot.
// - Unequal branches take when the full source values differ.
// - Special opcode with function 001101 is the debug trap.
// - The debug trap raises a breakpoint exception at once.
// - The trap's 20-bit field is not handed to the handler.
// - Opcode 101111 is line maintenance with base, selector, offset.
// - Address is sign-extended offset plus base, sent for translation.
// - Unprivileged with the enable bit clear raises coprocessor unusable.
// - Unlisted combinations and unknown caches are left undefined.
// - Index ops pick the block from address bits store-1 to block.
// - Index tag read picks the doubleword with bits block-1 to 3.
// - With parity override set, fill writes parity from the error reg.
// - Hit ops act only on a valid block with a matching tag.
// - Bits 17 to 16 choose instruction or data cache.
// - Bits 20 to 18 give the maintenance operation code.
module btc_decode (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [63:0] instr_pc,
  input wire logic [63:0] src_a,
  input wire logic [63:0] src_b,
  input wire logic blk_valid,
  input wire logic tag_match,
  output btc_pkg::btc_pipe_s pipe_out,
  output btc_pkg::btc_creq_s creq_out,
  output logic cache_act,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  btc_pkg::btc_state_s st;
  btc_pkg::btc_state_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fields
  logic [5:0] opc;
  logic [4:0] rs_f;
  logic [4:0] rt_f;
  logic [5:0] fn;
  logic [15:0] ofs;
  logic [63:0] ofs_sx;
  logic [63:0] br_ofs;
  logic [63:0] slot_pc;
  logic [63:0] br_tgt;
  logic [63:0] vaddr;
  logic mode64;
  logic is_register_immediate_class;
  logic is_bnl;
  logic is_bnll;
  logic is_bnlk;
  logic is_bne;
  logic is_branch_unequal_likely;
  logic is_trap;
  logic is_line;
  logic is_neg;
  logic is_link;
  logic is_br;
  logic neg_cond;
  logic ne_cond;
  logic [1:0] csel;
  logic [2:0] mop;
  logic hit_op;
  logic scc_ok;

  assign opc = instr[31:26];
  assign rs_f = instr[25:21];
  assign rt_f = instr[20:16];
  assign fn = instr[5:0];
  assign ofs = instr[15:0];
  assign mode64 = st.ctrl[`BTC_CTRL_MODE64];
  assign ofs_sx = {{48{ofs[15]}}, ofs};
  assign br_ofs = {{46{ofs[15]}}, ofs, 2'b00};
  assign slot_pc = instr_pc + 64'h0000_0000_0000_0004;
  // In 32-bit mode the sum wraps in the low word and is sign-extended
  always_comb begin
    br_tgt = slot_pc + br_ofs;
    vaddr = src_a + ofs_sx;
    if (!mode64) begin
      br_tgt = {{32{br_tgt[31]}}, br_tgt[31:0]};
      vaddr = {{32{vaddr[31]}}, vaddr[31:0]};
    end
  end

  assign is_register_immediate_class = (opc == `BTC_OP_REGISTER_IMMEDIATE_CLASS);
  assign is_bnl = is_register_immediate_class && (rt_f == `BTC_RT_BNL);
  assign is_bnll = is_register_immediate_class && (rt_f == `BTC_RT_BNLL);
  assign is_bnlk = is_register_immediate_class && (rt_f == `BTC_RT_BNLK);
  assign is_bne = (opc == `BTC_OP_BNE);
  assign is_branch_unequal_likely = (opc == `BTC_OP_BRANCH_UNEQUAL_LIKELY);
  assign is_trap = (opc == `BTC_OP_SPECIAL) && (fn == `BTC_FN_TRAP);
  assign is_line = (opc == `BTC_OP_LINE);
  assign is_neg = is_bnl || is_bnll || is_bnlk;
  assign is_link = is_bnl || is_bnll;
  assign is_br = is_neg || is_bne || is_branch_unequal_likely;

  // Source values are the pre-link contents presented this cycle
  assign neg_cond = mode64 ? src_a[63] : src_a[31];
  assign ne_cond = (src_a != src_b);

  assign csel = instr[17:16];
  assign mop = instr[20:18];
  // Fill shares code 5 with the data cache write back, so check the cache
  assign hit_op = (mop == `BTC_MOP_HITINV) || (mop == `BTC_MOP_HITWB) ||
    ((mop == `BTC_MOP_HITWBI) && (csel == `BTC_CACHE_D));
  assign scc_ok = st.ctrl[`BTC_CTRL_KERNEL] || st.ctrl[`BTC_CTRL_SCC_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Register access decode
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [31:0] wmask;

  assign wr_fire = st.aw_have && st.w_have && !st.bvalid;
  assign rd_fire = s_axi_arvalid && !st.rvalid;

  generate
    for (genvar b = 0; b < 4; b++) begin : g_mask
      assign wmask[8*b+:8] = {8{st.wstrb[b]}};
    end
  endgenerate

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `BTC_CTRL_OFS: rd_val = {28'h000_0000, st.ctrl};
      `BTC_PARITY_ERROR_REGISTER_OFS: rd_val = {24'h00_0000, st.parity_error_register};
      `BTC_STAT_OFS: rd_val = {28'h000_0000, st.evt,
        (st.fsm == btc_pkg::BTC_SLOT)};
      default: rd_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [2:0] evt_set;
    logic [31:0] wv;
    evt_set = 3'h0;
    wv = 32'h0000_0000;
    next_st = st;
    next_st.po.redirect = 1'b0;
    next_st.po.nullify = 1'b0;
    next_st.po.link_we = 1'b0;
    next_st.po.brk_exc = 1'b0;
    next_st.po.cpu_exc = 1'b0;
    next_st.creq.go = 1'b0;

    unique case (st.fsm)
      btc_pkg::BTC_IDLE: begin
        if (instr_valid && is_br) begin
          next_st.fsm = btc_pkg::BTC_SLOT;
          next_st.pend_taken = is_neg ? neg_cond : ne_cond;
          next_st.pend_likely = is_bnll || is_bnlk || is_branch_unequal_likely;
          next_st.pend_target = br_tgt;
        end
      end
      btc_pkg::BTC_SLOT: begin
        // Wait for the one delay slot instruction to issue
        if (instr_valid) begin
          next_st.fsm = btc_pkg::BTC_IDLE;
          next_st.po.redirect = st.pend_taken;
          next_st.po.target = st.pend_target;
          next_st.po.nullify = st.pend_likely && !st.pend_taken;
        end
      end
    endcase

    if (instr_valid && is_link) begin
      // Written regardless of outcome; rs of 31 simply reads the old value
      next_st.po.link_we = 1'b1;
      next_st.po.link_idx = `BTC_LINK_REG;
      next_st.po.link_data = instr_pc + 64'h0000_0000_0000_0008;
    end

    // Code field is never copied out; the handler reloads the word
    if (instr_valid && is_trap) begin
      next_st.po.brk_exc = 1'b1;
      evt_set[0] = 1'b1;
    end

    if (instr_valid && is_line) begin
      if (!scc_ok) begin
        next_st.po.cpu_exc = 1'b1;
        evt_set[1] = 1'b1;
      end else if (!csel[1]) begin
        // Cache codes 2 and 3 are dropped; results there are undefined
        next_st.creq.go = 1'b1;
        next_st.creq.cache_sel = csel;
        next_st.creq.mop = mop;
        next_st.creq.vaddr = vaddr;
        next_st.creq.index =
          vaddr[`BTC_STORE_LOG2-1:`BTC_BLOCK_LOG2];
        next_st.creq.dword = vaddr[`BTC_BLOCK_LOG2-1:3];
        next_st.creq.hit_op = hit_op;
        next_st.creq.use_parity_error_register = st.ctrl[`BTC_CTRL_PAR_OVR];
        next_st.creq.parity_error_register = st.parity_error_register;
      end else begin
        evt_set[2] = 1'b1;
      end
    end

    // AXI4-Lite write side: address and data accepted in either order
    if (s_axi_awvalid && !st.aw_have && !st.bvalid) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_have && !st.bvalid) begin
      next_st.w_have = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `BTC_RESP_OKAY;
      case (st.aw_addr)
        `BTC_CTRL_OFS: begin
          wv = ({28'h000_0000, st.ctrl} & ~wmask) | (st.wdata & wmask);
          next_st.ctrl = wv[3:0];
        end
        `BTC_PARITY_ERROR_REGISTER_OFS: begin
          wv = ({24'h00_0000, st.parity_error_register} & ~wmask) | (st.wdata & wmask);
          next_st.parity_error_register = wv[7:0];
        end
        `BTC_STAT_OFS: begin
          if (st.wstrb[0]) begin
            next_st.evt = st.evt & ~st.wdata[3:1];
          end
        end
        default: next_st.bresp = `BTC_RESP_SLVERR;
      endcase
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Hardware setting an event wins over a clear in the same cycle
    next_st.evt = next_st.evt | evt_set;

    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_val;
      next_st.rresp = rd_ok ? `BTC_RESP_OKAY : `BTC_RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.fsm <= btc_pkg::BTC_IDLE;
      st.ctrl <= `BTC_CTRL_RST;
      st.parity_error_register <= `BTC_PARITY_ERROR_REGISTER_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pipe_out = st.po;
  assign creq_out = st.creq;
  // Cache answers the registered request combinationally in the same cycle
  assign cache_act = st.creq.go &&
    (!st.creq.hit_op || (blk_valid && tag_match));

  assign s_axi_awready = !st.aw_have && !st.bvalid;
  assign s_axi_wready = !st.w_have && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

endmodule

// ==== btc_decode_monitor.sv ====
// Concurrent checks on the decoder's instruction and cache ports
`timescale 1ns/100ps
module btc_decode_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [63:0] instr_pc,
  input wire logic [63:0] src_a,
  input wire logic blk_valid,
  input wire logic tag_match,
  input wire btc_pkg::btc_pipe_s pipe_out,
  input wire btc_pkg::btc_creq_s creq_out,
  input wire logic cache_act
);
  logic slot_q;
  logic br;
  logic first;
  logic [5:0] op;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  assign op = instr[31:26];
  assign first = instr_valid && !slot_q;
  assign br = op == 6'h05 || op == 6'h15 || op == 6'h01
    && (instr[20:16] == 5'h10 || instr[20:16] == 5'h12
    || instr[20:16] == 5'h02);
  // A branch seen in a slot opens no new slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_q <= 1'b0;
    end else if (instr_valid) begin
      slot_q <= first && br;
    end
  end
  ////////////////////////////////////////////////////////////////////
  a_trap_breaks:
    assert property (first && op == 6'h00 && instr[5:0] == 6'h0D
      |=> pipe_out.brk_exc) else $error("trap gave no break");
  a_link_pc8:
    assert property (first && br && op == 6'h01 && instr[20]
      |=> pipe_out.link_we && pipe_out.link_idx == 5'h1F
      && pipe_out.link_data == $past(instr_pc) + 64'd8)
      else $error("link write wrong");
  a_redirect_slot:
    assert property (pipe_out.redirect |-> $past(instr_valid && slot_q))
      else $error("redirect without slot");
  a_null_alone:
    assert property (pipe_out.nullify
      |-> !pipe_out.redirect && $past(instr_valid && slot_q))
      else $error("bad nullify");
  a_line_fields:
    assert property (creq_out.go |-> $past(op) == 6'h2F
      && creq_out.mop == $past(instr[20:18])
      && creq_out.cache_sel == $past(instr[17:16]))
      else $error("cache request fields wrong");
  a_code_refused:
    assert property (instr_valid && op == 6'h2F && instr[17]
      |=> !creq_out.go) else $error("undefined cache code went");
  a_index_bits:
    assert property (creq_out.go |-> creq_out.dword == creq_out.vaddr[3]
      && creq_out.index == creq_out.vaddr[11:4])
      else $error("index bits wrong");
  a_vaddr_sum:
    assert property (creq_out.go |-> creq_out.vaddr[31:0]
      == $past(src_a[31:0])
      + {{16{$past(instr[15])}}, $past(instr[15:0])})
      else $error("line address sum wrong");
  a_hit_gate:
    assert property (creq_out.go && creq_out.hit_op
      && !(blk_valid && tag_match) |-> !cache_act)
      else $error("hit op acted on a miss");
endmodule
bind btc_decode btc_decode_monitor i_btc_decode_monitor (
  .aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid),
  .instr(instr), .instr_pc(instr_pc), .src_a(src_a), .blk_valid(blk_valid),
  .tag_match(tag_match), .pipe_out(pipe_out), .creq_out(creq_out),
  .cache_act(cache_act)
);

// ==== btc_decode_tb_top.sv ====
// Self-checking bench for the branch, trap and line maintenance decoder
`timescale 1ns/100ps
`include "btc_regs.svh"
module btc_decode_tb_top;
  typedef struct packed {
    logic [31:0] ins;
    logic [63:0] a;
    logic [63:0] b;
    logic [4:0] e;
  } btc_row_s;
  localparam logic [63:0] PC = 64'h1000;
  logic aclk, aresetn, instr_valid, blk_valid, tag_match, cache_act;
  logic [31:0] instr, s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  logic [31:0] s_axi_rdata, q;
  logic [63:0] instr_pc, src_a, src_b;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  btc_pkg::btc_pipe_s pipe_out;
  btc_pkg::btc_creq_s creq_out;
  int mismatches, total_checks;
  btc_row_s rows [12];
  btc_decode i_btc_decode (
    .aclk, .aresetn, .instr_valid, .instr, .instr_pc, .src_a, .src_b,
    .blk_valid, .tag_match, .pipe_out, .creq_out, .cache_act,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  always #25 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task ck(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [63:0] tg(input logic [31:0] i);
    return PC + 64'd4 + {{46{i[15]}}, i[15:0], 2'b00};
  endfunction
  // Cache answers ride on src_b bits 1:0; k keeps valid for a slot
  task go(input logic [31:0] i, input logic [63:0] a, b, input logic k);
    if (!instr_valid) @(posedge aclk);
    instr_valid <= 1'b1;
    instr <= i;
    instr_pc <= PC;
    src_a <= a;
    src_b <= b;
    blk_valid <= b[1];
    tag_match <= b[0];
    @(posedge aclk);
    if (!k) begin
      instr_valid <= 1'b0;
      @(negedge aclk);
    end
  endtask
  // Readies are sampled mid-cycle so no edge race decides a handshake
  task bus(input logic w, input logic [31:0] a, d);
    logic av, wv, ta, tw, tr;
    int n;
    @(posedge aclk);
    av = 1'b1;
    wv = w;
    tr = 1'b0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    for (n = 0; n < 20 && !tr; n++) begin
      @(negedge aclk);
      ta = av && (w ? s_axi_awready : s_axi_arready);
      tw = wv && s_axi_wready;
      tr = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      av = av && !ta;
      wv = wv && !tw;
      s_axi_awvalid <= av && w;
      s_axi_arvalid <= av && !w;
      s_axi_wvalid <= wv;
      s_axi_bready <= w && !tr;
      s_axi_rready <= !w && !tr;
    end
    if (!tr) begin
      mismatches++;
      $display("BAD %0t bus answer timed out", $time);
      report_and_stop;
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    {aclk, aresetn, instr_valid, blk_valid, tag_match} = '0;
    {instr, instr_pc, src_a, src_b} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    rows = '{'{32'h04B0_0004, 64'h8000_0000, 64'h0, 5'b10010},
      '{32'h04B2_FFFE, 64'h0, 64'h0, 5'b10001},
      '{32'h04A2_0010, 64'h1, 64'h0, 5'b00001},
      '{32'h14A6_0008, 64'h1, 64'h2, 5'b00010},
      '{32'h14A6_0008, 64'h5, 64'h5, 5'b00000},
      '{32'h54A6_FFF0, 64'h5, 64'h5, 5'b00001},
      '{32'h02AF_378D, 64'h0, 64'h0, 5'b01000},
      '{32'h07F0_0004, 64'h8000_0000, 64'h0, 5'b10010},
      '{32'hBC71_FFF8, 64'h0, 64'h0, 5'b00100},
      '{32'h04A2_0010, 64'h8000_0000, 64'h0, 5'b00001},
      '{32'h04A2_0010, 64'h8000_0000_0000_0000, 64'h0, 5'b00010},
      '{32'h54A6_FFF0, 64'h1_0000_0000, 64'h0, 5'b00010}};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      if (i == 9) bus(1'b1, `BTC_CTRL_OFS, 32'h1);
      go(rows[i].ins, rows[i].a, rows[i].b, 1'b0);
      ck(pipe_out.link_we, rows[i].e[4]);
      ck(pipe_out.brk_exc, rows[i].e[3]);
      ck(pipe_out.cpu_exc, rows[i].e[2]);
      if (rows[i].e[4]) ck(pipe_out.link_data, PC + 64'd8);
      go(32'h0, 64'h0, 64'h0, 1'b0);
      ck(pipe_out.redirect, rows[i].e[1]);
      ck(pipe_out.nullify, rows[i].e[0]);
      if (rows[i].e[1]) ck(pipe_out.target, tg(rows[i].ins));
    end
    bus(1'b1, `BTC_CTRL_OFS, 32'h6);
    go(32'hBC71_FFF8, 64'h1234_5670, 64'h1, 1'b0);
    ck(creq_out.vaddr, 64'h1234_5668);
    ck({creq_out.index, creq_out.dword, cache_act}, 10'h19A);
    go(32'hBC71_FFF8, 64'h1234_5670, 64'h3, 1'b0);
    ck(cache_act, 1'b1);
    go(32'hBC61_FFF8, 64'h1234_5670, 64'h0, 1'b0);
    ck({creq_out.go, creq_out.mop, cache_act}, 5'b10001);
    go(32'hBC62_FFF8, 64'h1234_5670, 64'h3, 1'b0);
    ck(creq_out.go, 1'b0);
    bus(1'b0, `BTC_STAT_OFS, 32'h0);
    ck(q[3:0], 4'hE);
    bus(1'b1, `BTC_PARITY_ERROR_REGISTER_OFS, 32'hA5);
    bus(1'b1, `BTC_CTRL_OFS, 32'hA);
    go(32'hBC74_0000, 64'h2000, 64'h0, 1'b0);
    ck({creq_out.use_parity_error_register, creq_out.parity_error_register, cache_act}, 10'h34B);
    bus(1'b0, 32'h10, 32'h0);
    ck({r, q}, {`BTC_RESP_SLVERR, 32'h0});
    bus(1'b1, 32'h10, 32'h0);
    ck(r, `BTC_RESP_SLVERR);
    bus(1'b1, `BTC_STAT_OFS, 32'hE);
    ck(r, `BTC_RESP_OKAY);
    bus(1'b0, `BTC_STAT_OFS, 32'h0);
    ck(q[3:0], 4'h0);
    go(32'h14A6_0008, 64'h1, 64'h2, 1'b1);
    go(32'h04B0_0004, 64'h8000_0000, 64'h0, 1'b0);
    ck({pipe_out.redirect, pipe_out.link_we}, 2'b11);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, `BTC_CTRL_OFS, 32'h0);
    ck(q, 32'h0);
    report_and_stop;
  end
endmodule
